// [hw/rssd_pkg.sv]
package rssd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and register map
    localparam int CLK_PERIOD_NS = 50;
    localparam int ADDR_W = 4;
    localparam int CNT_W = 17;
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_FUSES = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    localparam logic [3:0] OFS_VECTORS = 4'hc;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Control register fields
    localparam int CTL_VTS_BIT = 0;
    localparam int CTL_DBG_BIT = 1;
    localparam logic [1:0] CTL_RESET = 2'h0;

    // Fuse register fields; a fuse bit reads 0 when programmed
    localparam int FUSE_CLOCK_SELECT_FUSES_LSB = 0;
    localparam int FUSE_LEVEL_BIT = 4;
    localparam int FUSE_BROWNOUT_ENABLE_FUSE_BIT = 5;
    localparam int FUSE_BOOT_BIT = 6;
    localparam logic [6:0] FUSE_RESET = 7'h72;
    localparam logic FUSE_PROGRAMMED = 1'b0;

    // Status register fields
    localparam int ST_CORE_RST_BIT = 0;
    localparam int ST_PWRUP_BIT = 1;
    localparam int ST_REQ_LSB = 2;
    localparam int ST_REAL_BIT = 8;
    localparam int ST_CLOCK_BIT = 9;
    localparam int ST_WAKE_BIT = 10;

    // Vector register fields and vector addresses (word addresses)
    localparam int VEC_INT_LSB = 16;
    localparam logic [13:0] RST_VEC_APP = 14'h0000;
    localparam logic [13:0] RST_VEC_BOOT = 14'h3800;
    localparam logic [13:0] INT_BASE_APP = 14'h0002;
    localparam logic [13:0] INT_BASE_BOOT = 14'h3802;
    localparam logic [13:0] INT_LAST_BOOT = 14'h3826;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int EXT_MIN_NS = 500;
    localparam int EXT_MIN_CYC =
        (EXT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SHORT_LO_US = 30;
    localparam int SHORT_HI_US = 10;
    localparam int OSC_SHORT_CYC = 8;
    localparam int OSC_LO_DIV =
        (SHORT_LO_US * 1000 / OSC_SHORT_CYC) / CLK_PERIOD_NS;
    localparam int OSC_HI_DIV =
        (SHORT_HI_US * 1000 / OSC_SHORT_CYC) / CLK_PERIOD_NS;
    localparam int OSC_SHORT_BOD_CYC = 32;
    localparam int OSC_FAST_LO_CYC = 1024;
    localparam int OSC_FAST_HI_CYC = 4096;
    localparam int OSC_SLOW_LO_CYC = 16384;
    localparam int OSC_SLOW_HI_CYC = 65536;
    localparam int CK_SHORT_CYC = 6;
    localparam int CK_1K_CYC = 1024;
    localparam int CK_16K_CYC = 16384;
    localparam int CK_32K_CYC = 32768;
    localparam int PWRUP_EXTRA_US = 600;
    localparam int PWRUP_EXTRA_CYC =
        PWRUP_EXTRA_US * 1000 / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        RSSD_HOLD,
        RSSD_PWRUP,
        RSSD_REAL,
        RSSD_CLOCK,
        RSSD_RUN,
        RSSD_WAKE
    } rssd_state_t;

endpackage

// [hw/rssd_tmr_if.sv]
`timescale 1ns/1ps
interface rssd_tmr_if;
    import rssd_pkg::*;
    logic load;
    logic [CNT_W-1:0] load_val;
    logic tick;
    logic done;
    modport ctl (output load, output load_val, output tick, input done);
    modport tmr (input load, input load_val, input tick, output done);
endinterface

// [hw/rssd_timer.sv]
`timescale 1ns/1ps
module rssd_timer
    import rssd_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    rssd_tmr_if.tmr bus
);

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;

    // Load wins over a tick; counting stops at zero
    assign cnt_next = bus.load ? bus.load_val :
        ((bus.tick && cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg);
    assign bus.done = (cnt_reg == '0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

endmodule // rssd_timer

// [hw/rssd_top.sv]
// Functional notes
// - Five reset requests, any one resets core
// - Hold reset while supply under power-on level
// - Pin low beyond 500 ns gives reset
// - Watchdog reset only when enabled and expired
// - Hold reset while supply under brown-out level
// - Hold reset while debug reset bit set
// - Reset clears I/O registers, fetch reset vector
// - Boot fuse moves reset vector; vectors base 002
// - Vector select moves vectors to 3802 onward
// - Fuse bit one unprogrammed, zero programmed
// - Codes 0000-0111 append six core clocks
// - Slow codes use 67 or 92 ms; code gives 61.44 or 81.92 ms
// - Fast codes use 4.2 or 5.8 ms; code gives 3.84 or 5.12 ms
// - Short codes use 30 or 10 us
// - Brown-out enable adds 100 us, low level; code adds 90 us
// - Power-up start adds about 0.6 ms
// - Brown-out enable adds 25 us, high level; code adds 30 us
// - Real part counts watchdog oscillator cycles
// - Watchdog pulse one clock, delay after it
// - Supply drop reasserts reset at once
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module rssd_top
    import rssd_pkg::*;
#(
    parameter int OSC_SLOW_LO = OSC_SLOW_LO_CYC,
    parameter int OSC_SLOW_HI = OSC_SLOW_HI_CYC,
    parameter int CK_16K = CK_16K_CYC,
    parameter int CK_32K = CK_32K_CYC,
    parameter int PWRUP_CYC = PWRUP_EXTRA_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic power_on_low,
    input wire logic reset_pin_n,
    input wire logic wdt_enable,
    input wire logic wdt_timeout,
    input wire logic brownout_low,
    input wire logic wake_from_sleep,
    output logic core_reset_n,
    output logic core_stall,
    output logic [13:0] reset_vector,
    output logic [13:0] int_vector_base
);

    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic [1:0] ctl_reg;
    logic [6:0] fuse_reg;
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state
    rssd_state_t state_reg;
    rssd_state_t state_next;
    logic pwrup_reg;
    logic [3:0] ext_cnt_reg;
    logic [6:0] osc_div_reg;
    logic osc_tick_reg;
    logic [13:0] rst_vec_reg;
    logic [13:0] int_base_reg;

    rssd_tmr_if tmr ();

    rssd_timer u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .bus(tmr.tmr)
    );

    ////////////////////////////////////////////////////////////////////////
    // Fuse decode, programmed reads as zero
    logic [3:0] clock_select_fuses;
    logic level_high;
    logic bod_on;
    logic boot_on;
    assign clock_select_fuses = fuse_reg[FUSE_CLOCK_SELECT_FUSES_LSB +: 4];
    assign level_high = (fuse_reg[FUSE_LEVEL_BIT] == FUSE_PROGRAMMED);
    assign bod_on = (fuse_reg[FUSE_BROWNOUT_ENABLE_FUSE_BIT] == FUSE_PROGRAMMED);
    assign boot_on = (fuse_reg[FUSE_BOOT_BIT] == FUSE_PROGRAMMED);

    // Clock-select classes of the real-time part
    logic cls_short;
    logic cls_fast;
    assign cls_short = (clock_select_fuses == 4'h1) || (clock_select_fuses == 4'h4) ||
        (clock_select_fuses == 4'h7) || (clock_select_fuses == 4'hc) || (clock_select_fuses == 4'hf);
    assign cls_fast = (clock_select_fuses == 4'h0) || (clock_select_fuses == 4'h3) ||
        (clock_select_fuses == 4'h6) || (clock_select_fuses == 4'hb) || (clock_select_fuses == 4'he);

    // Real-time part in watchdog oscillator cycles
    logic [CNT_W-1:0] short_cyc;
    logic [CNT_W-1:0] fast_cyc;
    logic [CNT_W-1:0] slow_cyc;
    logic [CNT_W-1:0] real_cyc;
    // Brown-out extension: 8 osc cycles become 32
    assign short_cyc = bod_on ? CNT_W'(OSC_SHORT_BOD_CYC) :
        CNT_W'(OSC_SHORT_CYC);
    assign fast_cyc = level_high ? CNT_W'(OSC_FAST_HI_CYC) :
        CNT_W'(OSC_FAST_LO_CYC);
    assign slow_cyc = level_high ? CNT_W'(OSC_SLOW_HI) :
        CNT_W'(OSC_SLOW_LO);
    assign real_cyc = cls_short ? short_cyc :
        (cls_fast ? fast_cyc : slow_cyc);

    // Core clock part appended after the real-time part
    logic [CNT_W-1:0] clk_cyc;
    assign clk_cyc = (clock_select_fuses < 4'h8) ? CNT_W'(CK_SHORT_CYC) :
        (clock_select_fuses == 4'h8) ? CNT_W'(CK_32K) :
        (clock_select_fuses >= 4'ha && clock_select_fuses <= 4'hc) ? CNT_W'(CK_16K) :
        CNT_W'(CK_1K_CYC);

    ////////////////////////////////////////////////////////////////////////
    // Reset requests
    logic ext_req;
    logic wdt_req;
    logic bod_req;
    logic dbg_req;
    logic any_req;
    logic ext_full;
    // Low must outlast the minimum width, so request on the sample after
    assign ext_full = (ext_cnt_reg == 4'(EXT_MIN_CYC));
    assign ext_req = !reset_pin_n && ext_full;
    assign wdt_req = wdt_enable && wdt_timeout;
    assign bod_req = bod_on && brownout_low;
    assign dbg_req = ctl_reg[CTL_DBG_BIT];
    assign any_req = power_on_low || ext_req || wdt_req || bod_req ||
        dbg_req;

    // Pin low-width filter, saturating
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_cnt_reg <= 4'h0;
        end else if (reset_pin_n) begin
            ext_cnt_reg <= 4'h0;
        end else if (!ext_full) begin
            ext_cnt_reg <= ext_cnt_reg + 4'h1;
        end
    end

    // Watchdog oscillator tick; rate follows the brown-out level
    logic [6:0] osc_div_top;
    assign osc_div_top = level_high ? 7'(OSC_HI_DIV - 1) :
        7'(OSC_LO_DIV - 1);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_div_reg <= 7'h00;
            osc_tick_reg <= 1'b0;
        end else begin
            osc_tick_reg <= (osc_div_reg >= osc_div_top);
            osc_div_reg <= (osc_div_reg >= osc_div_top) ? 7'h00 :
                osc_div_reg + 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Start-up sequencer
    always_comb begin
        state_next = state_reg;
        tmr.load = 1'b0;
        tmr.load_val = '0;
        if (any_req) begin
            state_next = RSSD_HOLD;
        end else begin
            case (state_reg)
                RSSD_HOLD: begin
                    tmr.load = 1'b1;
                    if (pwrup_reg) begin
                        state_next = RSSD_PWRUP;
                        tmr.load_val = CNT_W'(PWRUP_CYC);
                    end else begin
                        state_next = RSSD_REAL;
                        tmr.load_val = real_cyc;
                    end
                end
                RSSD_PWRUP: begin
                    if (tmr.done) begin
                        state_next = RSSD_REAL;
                        tmr.load = 1'b1;
                        tmr.load_val = real_cyc;
                    end
                end
                RSSD_REAL: begin
                    if (tmr.done) begin
                        state_next = RSSD_CLOCK;
                        tmr.load = 1'b1;
                        tmr.load_val = clk_cyc;
                    end
                end
                RSSD_CLOCK: begin
                    if (tmr.done) begin
                        state_next = RSSD_RUN;
                    end
                end
                RSSD_RUN: begin
                    // Deep-sleep wake skips the real-time part
                    if (wake_from_sleep) begin
                        state_next = RSSD_WAKE;
                        tmr.load = 1'b1;
                        tmr.load_val = clk_cyc;
                    end
                end
                RSSD_WAKE: begin
                    if (tmr.done) begin
                        state_next = RSSD_RUN;
                    end
                end
                default: begin
                    state_next = RSSD_HOLD;
                end
            endcase
        end
    end

    // Real part counts osc ticks, other parts count core clocks
    assign tmr.tick = (state_reg == RSSD_REAL) ? osc_tick_reg : 1'b1;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= RSSD_HOLD;
        end else begin
            state_reg <= state_next;
        end
    end

    // Power-up mark, spent after the extra time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwrup_reg <= 1'b1;
        end else if (power_on_low) begin
            pwrup_reg <= 1'b1;
        end else if (state_reg == RSSD_PWRUP && tmr.done && !any_req) begin
            pwrup_reg <= 1'b0;
        end
    end

    // Combinational so a supply drop asserts reset in the same cycle
    logic run_ok;
    assign run_ok = (state_reg == RSSD_RUN) || (state_reg == RSSD_WAKE);
    assign core_reset_n = run_ok && !any_req;
    assign core_stall = (state_reg == RSSD_WAKE);

    // Vector placement, registered for the fetch unit
    logic [13:0] int_base_sel;
    assign int_base_sel = ctl_reg[CTL_VTS_BIT] ? INT_BASE_BOOT :
        INT_BASE_APP;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_vec_reg <= RST_VEC_APP;
            int_base_reg <= INT_BASE_APP;
        end else begin
            rst_vec_reg <= boot_on ? RST_VEC_BOOT : RST_VEC_APP;
            int_base_reg <= int_base_sel;
        end
    end
    assign reset_vector = rst_vec_reg;
    assign int_vector_base = int_base_reg;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path; address and data taken in either order
    logic aw_take;
    logic w_take;
    logic wr_fire;
    logic wr_ctl;
    logic wr_fuse;
    logic wr_known;
    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready = !w_hold_reg && !bvalid_reg;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
    assign wr_ctl = wr_fire && (awaddr_reg == OFS_CONTROL) && wstrb_reg[0];
    assign wr_fuse = wr_fire && (awaddr_reg == OFS_FUSES) && wstrb_reg[0];
    assign wr_known = (awaddr_reg == OFS_CONTROL) ||
        (awaddr_reg == OFS_FUSES) || (awaddr_reg == OFS_STATUS) ||
        (awaddr_reg == OFS_VECTORS);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_hold_reg <= 1'b0;
            end
            if (w_take) begin
                w_hold_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_hold_reg <= 1'b0;
            end
        end
    end

    // Write response; unmapped offsets answer SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // Vector select is an I/O bit, cleared by core reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_reg <= CTL_RESET;
        end else begin
            if (wr_ctl) begin
                ctl_reg <= wdata_reg[1:0];
            end
            if (!core_reset_n) begin
                ctl_reg[CTL_VTS_BIT] <= 1'b0;
            end
        end
    end

    // Fuses take effect on the next start-up delay
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fuse_reg <= FUSE_RESET;
        end else if (wr_fuse) begin
            fuse_reg <= wdata_reg[6:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path
    logic ar_take;
    logic [31:0] status_word;
    logic [31:0] vector_word;
    logic [31:0] rd_word;
    logic rd_known;
    assign s_axi_arready = !rvalid_reg;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign status_word = {21'h000000,
        state_reg == RSSD_WAKE, state_reg == RSSD_CLOCK,
        state_reg == RSSD_REAL, 1'b0,
        dbg_req, bod_req, wdt_req, ext_req, power_on_low,
        pwrup_reg, !core_reset_n};
    assign vector_word = {2'h0, int_base_reg, 2'h0, rst_vec_reg};
    assign rd_known = (s_axi_araddr == OFS_CONTROL) ||
        (s_axi_araddr == OFS_FUSES) || (s_axi_araddr == OFS_STATUS) ||
        (s_axi_araddr == OFS_VECTORS);
    assign rd_word = (s_axi_araddr == OFS_CONTROL) ? {30'h0, ctl_reg} :
        (s_axi_araddr == OFS_FUSES) ? {25'h0, fuse_reg} :
        (s_axi_araddr == OFS_STATUS) ? status_word :
        (s_axi_araddr == OFS_VECTORS) ? vector_word : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= rd_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

endmodule // rssd_top

// [bench/rssd_top_props.sv]
`timescale 1ns/1ps
module rssd_top_props
    import rssd_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic power_on_low,
    input wire logic reset_pin_n,
    input wire logic wdt_enable,
    input wire logic wdt_timeout,
    input wire logic core_reset_n,
    input wire logic core_stall,
    input wire logic [13:0] reset_vector,
    input wire logic [13:0] int_vector_base
);
    logic [3:0] pin_low_reg;

    ////////////////////////////////////////////////////////////////////////
    // Low pin run, saturating so it never wraps
    always_ff @(posedge aclk) begin
        if (!aresetn || reset_pin_n) pin_low_reg <= 4'h0;
        else if (pin_low_reg != 4'hf) pin_low_reg <= pin_low_reg + 4'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset request relations
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    por_hold_a: assert property (power_on_low |-> !core_reset_n)
        else $error("core ran at low supply");
    wdt_reset_a: assert property (
        wdt_enable && wdt_timeout |-> !core_reset_n ##1 !core_reset_n)
        else $error("watchdog reset missed");
    ext_pin_a: assert property (
        pin_low_reg >= 4'hc && !reset_pin_n |-> !core_reset_n)
        else $error("pin reset missed");
    restart_delay_a: assert property (
        $fell(power_on_low) |-> !core_reset_n [*6])
        else $error("delay skipped");
    release_quiet_a: assert property (
        $rose(core_reset_n) |-> !power_on_low && reset_pin_n)
        else $error("release under request");
    stall_run_a: assert property (core_stall |-> core_reset_n)
        else $error("stall in reset");
    vec_range_a: assert property (
        (reset_vector == RST_VEC_APP || reset_vector == RST_VEC_BOOT) &&
        (int_vector_base == INT_BASE_APP ||
        int_vector_base == INT_BASE_BOOT))
        else $error("bad vector");

    ////////////////////////////////////////////////////////////////////////
    // Register bus answers stand until taken
    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bresp dropped");
    rdata_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rdata dropped");
    read_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
endmodule // rssd_top_props

// [bench/rssd_env.sv]
`timescale 1ns/1ps
module rssd_env (
    input wire logic aclk,
    output logic power_on_low,
    output logic reset_pin_n,
    output logic wdt_enable,
    output logic wdt_timeout,
    output logic brownout_low,
    output logic wake_from_sleep
);
    // Quiet supply, pin pulled high, watchdog idle
    initial begin
        {power_on_low, wdt_enable, wdt_timeout} = 3'h0;
        {brownout_low, wake_from_sleep} = 2'h0;
        reset_pin_n = 1'b1;
    end

    // Level requests; caller keeps the pin low beyond 500 ns
    task set_req(input int src, input logic v);
        if (src == 0) power_on_low <= v;
        if (src == 1) reset_pin_n <= !v;
        if (src == 3) brownout_low <= v;
    endtask

    // Expiry is one clock wide
    task wdt_fire(input logic en);
        wdt_enable <= en;
        wdt_timeout <= 1'b1;
        @(posedge aclk);
        wdt_timeout <= 1'b0;
    endtask

    // One-cycle wake event
    task wake();
        wake_from_sleep <= 1'b1;
        @(posedge aclk);
        wake_from_sleep <= 1'b0;
    endtask
endmodule // rssd_env

// [bench/test_reset_source_startup_delay.sv]
`timescale 1ns/1ps
module test_reset_source_startup_delay;
    import rssd_pkg::*;
    // Small counts keep slow codes inside the run budget
    localparam int SLOW = 64;
    localparam int C16 = 20;
    localparam int C32 = 40;
    localparam int PWR = 30;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [3:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic power_on_low, reset_pin_n, wdt_enable, wdt_timeout, brownout_low;
    logic wake_from_sleep, core_reset_n, core_stall;
    logic [13:0] reset_vector, int_vector_base;
    int num_errors = 0;
    int n_tests = 0;
    int lo, hi, n, m, k;
    // Entries are {source, fuses}; source 0 por 1 pin 2 wdt 3 bod 4 debug
    logic [9:0] cases [12] = '{10'h231, 10'h114, 10'h187, 10'h0e8,
        10'h229, 10'h22a, 10'h22c, 10'h22d, 10'h22f, 10'h222, 10'h225,
        10'h021};

    rssd_top #(.OSC_SLOW_LO(SLOW), .OSC_SLOW_HI(SLOW), .CK_16K(C16),
        .CK_32K(C32), .PWRUP_CYC(PWR)) u_dut (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .power_on_low, .reset_pin_n, .wdt_enable,
        .wdt_timeout, .brownout_low, .wake_from_sleep, .core_reset_n,
        .core_stall, .reset_vector, .int_vector_base);
    rssd_env u_env (.*);

    ////////////////////////////////////////////////////////////////////////
    // Reporting
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task end_of_test();
        if (num_errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Bus cycles, sampled at the rising edge
    task axi_wr(input logic [3:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        repeat (100) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        check({29'h0, s_axi_bvalid, s_axi_bresp},
            {29'h0, 1'b1, RESP_OKAY});
        @(posedge aclk);
    endtask

    task axi_rd(input logic [3:0] a);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        repeat (100) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        {rd, rs} = {s_axi_rdata, s_axi_rresp};
        check({31'h0, s_axi_rvalid}, 32'h1);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Start-up window: osc ticks of unknown phase, then clocks
    task calc(input logic [6:0] f, input int pwr);
        int t, nn;
        t = f[4] ? OSC_LO_DIV : OSC_HI_DIV;
        nn = SLOW;
        if (f[3:0] inside {1, 4, 7, 12, 15})
            nn = f[5] ? OSC_SHORT_CYC : OSC_SHORT_BOD_CYC;
        m = CK_1K_CYC;
        if (f[3:0] < 8) m = CK_SHORT_CYC;
        else if (f[3:0] == 8) m = C32;
        else if (f[3:0] inside {10, 11, 12}) m = C16;
        lo = pwr + (nn - 1) * t + m;
        hi = pwr + nn * t + m + 16;
    endtask

    task settle();
        n = 0;
        while (core_reset_n !== 1'b1 && n < hi) begin
            @(negedge aclk);
            n++;
        end
        check({31'h0, n >= lo && core_reset_n === 1'b1}, 32'h1);
        @(posedge aclk);
    endtask

    // Raise one source, see the core held, drop it, time the release
    task run_case(input logic [9:0] e);
        int s;
        s = e[9:7];
        axi_wr(OFS_FUSES, {25'h0, e[6:0]});
        calc(e[6:0], (s == 0) ? PWR : 0);
        if (s == 2) begin
            u_env.wdt_fire(1'b0);
            repeat (3) @(posedge aclk);
            check({31'h0, core_reset_n}, 32'h1);
            u_env.wdt_fire(1'b1);
        end else if (s == 4) axi_wr(OFS_CONTROL, 32'h2);
        else u_env.set_req(s, 1'b1);
        repeat (12) @(posedge aclk);
        @(negedge aclk);
        check({31'h0, core_reset_n}, 32'h0);
        @(posedge aclk);
        if (s != 2) begin
            axi_rd(OFS_STATUS);
            check({30'h0, rd[ST_REQ_LSB + s], rd[0]}, 32'h3);
        end
        if (s == 4) axi_wr(OFS_CONTROL, 32'h0);
        else if (s != 2) u_env.set_req(s, 1'b0);
        settle();
        check({18'h0, reset_vector},
            {18'h0, e[6] ? RST_VEC_APP : RST_VEC_BOOT});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Clock, watchdog and main sequence
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    initial begin
        repeat (60000) @(posedge aclk);
        num_errors++;
        end_of_test();
    end

    initial begin
        aresetn = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid,
            s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 45'h0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        calc(FUSE_RESET, PWR);
        settle();
        axi_rd(OFS_FUSES);
        check(rd, 32'h72);
        axi_rd(OFS_VECTORS);
        check(rd, {2'h0, INT_BASE_APP, 2'h0, RST_VEC_APP});
        axi_rd(4'h6);
        check({30'h0, rs}, {30'h0, RESP_SLVERR});
        axi_wr(OFS_CONTROL, 32'h1);
        axi_rd(OFS_VECTORS);
        check(rd, {2'h0, INT_BASE_BOOT, 2'h0, RST_VEC_APP});
        for (k = 0; k < 12; k++) begin
            run_case(cases[k]);
            if (k == 0) begin
                axi_rd(OFS_CONTROL);
                check(rd, 32'h0);
                check({18'h0, int_vector_base}, {18'h0, INT_BASE_APP});
            end
        end
        // Wake runs only the clock part
        u_env.wake();
        n = 0;
        repeat (m + 4) begin
            @(negedge aclk);
            if (core_stall === 1'b1) n++;
        end
        check(n, m + 1);
        end_of_test();
    end
endmodule // test_reset_source_startup_delay

bind rssd_top rssd_top_props u_props (.*);
